// [srw_defines.svh]
`ifndef SRW_DEFINES_SVH
`define SRW_DEFINES_SVH

// ----------------------------------------------------------------------
// timebase
// ----------------------------------------------------------------------
`define SRW_CLK_FREQ_MHZ 125

// ----------------------------------------------------------------------
// intervals in their own units
// ----------------------------------------------------------------------
`define SRW_RESET_HOLD_TIME_MS 140
`define SRW_WATCHDOG_PERIOD_MS 1600
`define SRW_DEBOUNCE_TIME_NS 1000
`define SRW_DIP_TIME_NS 2000

// ----------------------------------------------------------------------
// strobe pull schedule: high for the last 1/N of the period
// ----------------------------------------------------------------------
`define SRW_PULL_HIGH_DIV 8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SRW_FILTER_INIT_SUPPLY 1'h1
`define SRW_FILTER_INIT_BUTTON 1'h1
`define SRW_WDO_RESET 1'h0
`define SRW_PULL_RESET 1'h0

`endif

// [srw_pkg.sv]
package srw_pkg;

  typedef enum logic [1:0] {
    st_undervolt,
    st_hold,
    st_run,
    st_manual
  } srw_state_type;

endpackage : srw_pkg

// [srw_level_filter.sv]
`timescale 1ns/100ps
`default_nettype none

// output follows the input only after it has been stable for CYCLES clocks
module srw_level_filter #(
  parameter int unsigned CYCLES = 125,
  parameter bit INIT = 1'h1
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic level_in,
  output var logic level_out
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
      level_out <= INIT;
    end else if (level_in == level_out) begin
      cnt_reg <= '0;
    end else if (cnt_reg == CNT_LAST) begin
      cnt_reg <= '0;
      level_out <= level_in;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

endmodule : srw_level_filter

`default_nettype wire

// [srw_supervisor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "srw_defines.svh"

module srw_supervisor #(
  parameter int unsigned RESET_HOLD_CYCLES =
    `SRW_RESET_HOLD_TIME_MS * 1000 * `SRW_CLK_FREQ_MHZ,
  parameter int unsigned WATCHDOG_PERIOD_CYCLES =
    `SRW_WATCHDOG_PERIOD_MS * 1000 * `SRW_CLK_FREQ_MHZ,
  parameter int unsigned DEBOUNCE_CYCLES =
    (`SRW_DEBOUNCE_TIME_NS * `SRW_CLK_FREQ_MHZ + 999) / 1000,
  parameter int unsigned DIP_CYCLES =
    (`SRW_DIP_TIME_NS * `SRW_CLK_FREQ_MHZ + 999) / 1000,
  parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic supply_low_in,
  input wire logic pushbutton_reset_n_in,
  input wire logic watchdog_strobe_in,
  output var logic reset_out,
  output var logic watchdog_expired_n_out,
  output var logic watchdog_strobe_pull_out,
  output var logic watchdog_disabled_out,
  output var srw_pkg::srw_state_type supervisor_state_out
);

  import srw_pkg::*;

  // ----------------------------------------------------------------------
  // widths and derived counts
  // ----------------------------------------------------------------------
  localparam int unsigned HOLD_W = $clog2(RESET_HOLD_CYCLES + 1);
  localparam int unsigned WD_W = $clog2(WATCHDOG_PERIOD_CYCLES + 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD_CYCLES - 1);
  localparam logic [WD_W-1:0] WD_LAST = WD_W'(WATCHDOG_PERIOD_CYCLES - 1);
  localparam logic [WD_W-1:0] PULL_SPLIT =
    WD_W'(WATCHDOG_PERIOD_CYCLES - WATCHDOG_PERIOD_CYCLES / `SRW_PULL_HIGH_DIV);
  localparam logic RESET_ON = RESET_ACTIVE_HIGH ? 1'h1 : 1'h0;
  localparam int unsigned FILT_CYCLES [2] = '{DIP_CYCLES, DEBOUNCE_CYCLES};
  localparam bit FILT_INIT [2] = '{`SRW_FILTER_INIT_SUPPLY, `SRW_FILTER_INIT_BUTTON};

  srw_state_type state_reg;
  srw_state_type state_next;
  logic [HOLD_W-1:0] hold_cnt_reg;
  logic [WD_W-1:0] wd_cnt_reg;
  logic strobe_prev_reg;
  logic pull_prev_reg;
  logic [1:0] raw_levels;
  logic [1:0] filt_levels;
  logic supply_low_filt;
  logic button_n_db;
  logic strobe_edge;
  logic pull_edge;
  logic drive_edge;
  logic wd_running;

  // ----------------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------------
  assign raw_levels = {pushbutton_reset_n_in, supply_low_in};

  // ch0 rejects supply dips, ch1 debounces the pushbutton
  generate
    for (genvar g = 0; g < 2; g++) begin : g_filt
      srw_level_filter #(
        .CYCLES(FILT_CYCLES[g]),
        .INIT(FILT_INIT[g])
      ) u_filt (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .level_in(raw_levels[g]),
        .level_out(filt_levels[g])
      );
    end
  endgenerate

  assign supply_low_filt = filt_levels[0];
  assign button_n_db = filt_levels[1];
  assign strobe_edge = watchdog_strobe_in != strobe_prev_reg;
  // an edge that tracks a pull change means nobody drives the pin
  assign pull_edge = strobe_edge && (pull_prev_reg != watchdog_strobe_pull_out)
    && (watchdog_strobe_in == watchdog_strobe_pull_out);
  assign drive_edge = strobe_edge && !pull_edge;
  assign wd_running = state_reg == st_run;

  // ----------------------------------------------------------------------
  // reset sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (supply_low_filt) begin
      state_next = st_undervolt;
    end else begin
      case (state_reg)
        st_undervolt: state_next = st_hold;
        st_hold: begin
          if (!button_n_db) begin
            state_next = st_manual;
          end else if (hold_cnt_reg == HOLD_LAST) begin
            state_next = st_run;
          end
        end
        st_run: begin
          if (!button_n_db) begin
            state_next = st_manual;
          end
        end
        st_manual: begin
          if (button_n_db) begin
            state_next = st_hold;
          end
        end
        default: state_next = st_undervolt;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= st_undervolt;
    end else begin
      state_reg <= state_next;
    end
  end

  // counter is cleared outside hold, so every entry restarts it
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_cnt_reg <= '0;
    end else if (state_reg == st_hold && state_next == st_hold) begin
      hold_cnt_reg <= hold_cnt_reg + HOLD_W'(1);
    end else begin
      hold_cnt_reg <= '0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reset_out <= RESET_ON;
    end else begin
      reset_out <= (state_reg != st_run) ? RESET_ON : ~RESET_ON;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      supervisor_state_out <= st_undervolt;
    end else begin
      supervisor_state_out <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // watchdog timer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_prev_reg <= 1'h0;
    end else begin
      strobe_prev_reg <= watchdog_strobe_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wd_cnt_reg <= '0;
    end else if (!wd_running) begin
      wd_cnt_reg <= '0;
    end else if (drive_edge || wd_cnt_reg == WD_LAST) begin
      wd_cnt_reg <= '0;
    end else begin
      wd_cnt_reg <= wd_cnt_reg + WD_W'(1);
    end
  end

  // expiry stays low until a driven strobe edge or a reset clears it
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      watchdog_expired_n_out <= `SRW_WDO_RESET;
    end else if (supply_low_filt || state_reg == st_undervolt) begin
      watchdog_expired_n_out <= 1'h0;
    end else if (!wd_running || drive_edge) begin
      watchdog_expired_n_out <= 1'h1;
    end else if (wd_cnt_reg == WD_LAST && !watchdog_disabled_out) begin
      watchdog_expired_n_out <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // open strobe detection
  // ----------------------------------------------------------------------
  // pull-tracking edges leave the count alone, so an open pin sees the
  // full low and high phases and the count wraps without an expiry
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      watchdog_strobe_pull_out <= `SRW_PULL_RESET;
    end else begin
      watchdog_strobe_pull_out <= wd_running && wd_cnt_reg >= PULL_SPLIT;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pull_prev_reg <= `SRW_PULL_RESET;
    end else begin
      pull_prev_reg <= watchdog_strobe_pull_out;
    end
  end

  // a driven edge re-arms the watchdog; a driven edge landing just after
  // a pull change is mistaken for an open pin until the next driven edge
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      watchdog_disabled_out <= 1'h0;
    end else if (strobe_edge) begin
      watchdog_disabled_out <= pull_edge;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_button_released;
    state_reg == st_manual && button_n_db && !supply_low_filt;
  endsequence

  sequence s_hold_restarted;
    state_reg == st_hold && hold_cnt_reg == '0;
  endsequence

  a_hold_min: assert property (
    state_reg == st_run && $past(state_reg) != st_run |->
      $past(state_reg) == st_hold && $past(hold_cnt_reg) == HOLD_LAST)
    else $error("reset released before full hold time");

  a_undervolt_reset: assert property (
    supply_low_filt |-> ##2 reset_out == RESET_ON)
    else $error("undervoltage did not assert reset");

  a_button_reset: assert property (
    !button_n_db && !supply_low_filt && state_reg != st_undervolt |->
      ##1 state_reg == st_manual ##1 reset_out == RESET_ON)
    else $error("pushbutton did not assert reset");

  a_debounce_len: assert property (
    $fell(button_n_db) |-> $past(pushbutton_reset_n_in) == 1'b0)
    else $error("debounced button fell without a low input");

  a_manual_restart: assert property (
    s_button_released |=> s_hold_restarted)
    else $error("manual hold did not start at release");

  a_wdog_timeout: assert property (
    wd_running && wd_cnt_reg == WD_LAST && !drive_edge && !supply_low_filt
      && !watchdog_disabled_out |=> !watchdog_expired_n_out)
    else $error("watchdog expiry missed");

  a_strobe_restart: assert property (
    wd_running && drive_edge |=> wd_cnt_reg == '0)
    else $error("strobe edge did not restart watchdog");

  a_wdog_idle: assert property (
    !wd_running |=> wd_cnt_reg == '0 && watchdog_strobe_pull_out == 1'b0)
    else $error("watchdog ran during reset");

  a_uv_wdo_low: assert property (
    supply_low_filt |=> !watchdog_expired_n_out)
    else $error("undervoltage did not force watchdog output low");

  a_pull_split: assert property (
    wd_running |=> watchdog_strobe_pull_out == ($past(wd_cnt_reg) >= PULL_SPLIT))
    else $error("strobe pull schedule wrong");

  a_pull_no_restart: assert property (
    wd_running && pull_edge && wd_cnt_reg != WD_LAST
      |=> wd_cnt_reg == $past(wd_cnt_reg) + 1)
    else $error("pull-tracking edge restarted watchdog");

  a_open_serviced: assert property (
    wd_running && watchdog_disabled_out && watchdog_expired_n_out && !supply_low_filt
      |=> watchdog_expired_n_out)
    else $error("open strobe pin let watchdog expire");

  a_dip_filter: assert property (
    $rose(supply_low_filt) |-> $past(supply_low_in, 1) && $past(supply_low_in, 2))
    else $error("supply dip passed filter");

  a_reset_level: assert property (
    ##1 reset_out == (($past(state_reg) != st_run) ? RESET_ON : ~RESET_ON))
    else $error("reset output polarity wrong");

endmodule : srw_supervisor

`default_nettype wire

// [srw_placeholder_end.sv]
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [srw_cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// processor side of the watchdog strobe pin
// ----------------------------------------------------------------------
// mode 0 drives low, 1 pulses high briefly, 2 releases the pin
module srw_cpu_model (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [1:0] mode_in,
  input wire logic pull_in,
  output var logic strobe_pin_out
);
  logic drv_reg;
  int unsigned tick_reg;

  // a processor held in reset runs no code, so no strobes then
  always_ff @(negedge sys_clk_in) begin
    if (!reset_n_in || mode_in != 2'h1) begin
      tick_reg <= 0;
      drv_reg <= 1'h0;
    end else begin
      tick_reg <= (tick_reg == 29) ? 0 : tick_reg + 1;
      drv_reg <= (tick_reg >= 27);
    end
  end

  // released pin shows only the weak pull, never the old drive
  always_comb strobe_pin_out = (mode_in == 2'h2) ? pull_in : drv_reg;
endmodule : srw_cpu_model

`default_nettype wire

// [srw_supervisor_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module srw_supervisor_tb_top;
  import srw_pkg::*;
  localparam int HOLD = 50;
  localparam int PERIOD = 80;
  localparam int DEB = 3;
  localparam int DIP = 4;

  logic sys_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic supply_low = 1'h0;
  logic pb_n = 1'h1;
  logic [1:0] mode = 2'h0;
  logic strobe, reset_out, wdo_n, pull, disabled;
  srw_state_type state;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  always #4 sys_clk_in = ~sys_clk_in;

  srw_supervisor #(.RESET_HOLD_CYCLES(HOLD), .WATCHDOG_PERIOD_CYCLES(PERIOD),
    .DEBOUNCE_CYCLES(DEB), .DIP_CYCLES(DIP)) srw_supervisor_i (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .supply_low_in(supply_low),
    .pushbutton_reset_n_in(pb_n), .watchdog_strobe_in(strobe),
    .reset_out(reset_out), .watchdog_expired_n_out(wdo_n),
    .watchdog_strobe_pull_out(pull), .watchdog_disabled_out(disabled),
    .supervisor_state_out(state));

  srw_cpu_model srw_cpu_model_i (.sys_clk_in(sys_clk_in), .reset_n_in(reset_out),
    .mode_in(mode), .pull_in(pull), .strobe_pin_out(strobe));

  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("tests=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : cycles

  // bounded wait for the given output level, returns cycles taken
  task automatic wait_for(ref logic sig, input logic lvl, output int n);
    n = 0;
    while (sig !== lvl && n < 500) begin
      @(negedge sys_clk_in);
      n++;
    end
  endtask : wait_for

  task automatic watch_lows(input int n, output int lows);
    lows = 0;
    repeat (n) begin
      @(negedge sys_clk_in);
      if (wdo_n !== 1'h1) lows++;
    end
  endtask : watch_lows

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic power_up();
    int n;
    cycles(10);
    check(reset_out, 1'h0);
    rst_in = 1'h0;
    wait_for(reset_out, 1'h1, n);
    check(n >= HOLD && n <= HOLD + DIP + 6, 1);
    check(state, st_run);
  endtask : power_up

  task automatic supply_dips();
    int n;
    supply_low = 1'h1;
    cycles(DIP - 1);
    supply_low = 1'h0;
    cycles(10);
    check(reset_out, 1'h1);
    supply_low = 1'h1;
    cycles(DIP + 3);
    check(reset_out, 1'h0);
    check(wdo_n, 1'h0);
    check(state, st_undervolt);
    cycles(30);
    check({reset_out, wdo_n}, 2'h0);
    supply_low = 1'h0;
    wait_for(reset_out, 1'h1, n);
    check(n >= HOLD && n <= HOLD + DIP + 6, 1);
  endtask : supply_dips

  task automatic manual_then_timeout();
    int n;
    pb_n = 1'h0;
    cycles(DEB - 1);
    pb_n = 1'h1;
    cycles(10);
    check(reset_out, 1'h1);
    pb_n = 1'h0;
    cycles(DEB + 3);
    check(reset_out, 1'h0);
    check(state, st_manual);
    cycles(PERIOD + 20);
    check({reset_out, wdo_n}, 2'h1);
    pb_n = 1'h1;
    wait_for(reset_out, 1'h1, n);
    check(n >= HOLD && n <= HOLD + DEB + 6, 1);
    wait_for(wdo_n, 1'h0, n);
    check(n >= PERIOD - 3 && n <= PERIOD + 2, 1);
  endtask : manual_then_timeout

  task automatic strobing();
    int lows;
    mode <= 2'h1;
    cycles(40);
    check(wdo_n, 1'h1);
    watch_lows(300, lows);
    check(lows, 0);
  endtask : strobing

  // pull low for the first 7/8 of a period, high for the last 1/8
  task automatic floating();
    int n, g, h, lows;
    mode <= 2'h2;
    wait_for(pull, 1'h1, n);
    wait_for(pull, 1'h0, n);
    wait_for(pull, 1'h1, g);
    check(g >= PERIOD * 7 / 8 - 2 && g <= PERIOD + 2, 1);
    wait_for(pull, 1'h0, h);
    check(h >= PERIOD / 8 - 1 && h <= PERIOD / 8 + 1, 1);
    watch_lows(300, lows);
    check(lows, 0);
    check(disabled, 1'h1);
  endtask : floating

  // ----------------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    power_up();
    supply_dips();
    manual_then_timeout();
    strobing();
    floating();
    tally_and_finish();
  end
endmodule : srw_supervisor_tb_top

`default_nettype wire
